// [cmd_ctrl_pkg.sv]
// Constants and carrier types for the PCI command register low byte block
package cmd_ctrl_pkg;

  // Register offset (configuration space byte address)
  localparam logic [7:0] cmd_reg_offset = 8'h04;
  localparam logic [7:0] stat_reg_offset = 8'h06;

  // Command and status register bit positions
  localparam int cmd_io_bit = 0;
  localparam int cmd_mem_bit = 1;
  localparam int cmd_bm_bit = 2;
  localparam int cmd_special_bit = 3;
  localparam int cmd_mwi_bit = 4;
  localparam int cmd_snoop_bit = 5;
  localparam int cmd_parity_bit = 6;
  localparam int cmd_step_bit = 7;
  localparam int stat_dpe_bit = 15;

  // Writable mask of the command word, reset value
  localparam logic [15:0] cmd_write_mask = 16'h0357;
  localparam logic [15:0] cmd_reset_value = 16'h0000;
  localparam logic [15:0] stat_fixed_value = 16'h0210;

  // Stepping capability encodings
  localparam logic [1:0] step_never = 2'h0;
  localparam logic [1:0] step_always = 2'h1;
  localparam logic [1:0] step_either = 2'h2;

  // Register image of the block
  typedef struct packed {
    logic [15:0] cmd;
    logic detected_parity_error_flag;
    logic perr_n;
    logic perr_oe;
  } cmd_state_t;

  // Configuration access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  // Enables handed to target and master logic
  typedef struct packed {
    logic mem_claim;
    logic io_claim;
    logic snoop_palette;
    logic special_monitor;
    logic master_ok;
    logic mwi_ok;
  } enables_t;

endpackage : cmd_ctrl_pkg

// [parity_gen.sv]
// Even parity generator for driven address/data and byte enables
`timescale 1ns/1ps
`default_nettype none
module parity_gen
  import cmd_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Driven bus values
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic drive,
  // Parity out
  output var logic par,
  output var logic par_oe
);

  // Parity follows the data phase by one clock, independent of checking
  always_ff @(posedge clock) begin
    if (!resetn) begin
      par <= 1'b0;
      par_oe <= 1'b0;
    end else begin
      par <= ^{ad, cbe};
      par_oe <= drive;
    end
  end

endmodule : parity_gen
`default_nettype wire

// [cmd_ctrl.sv]
// PCI command register low byte and the enables it applies
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Stepping bit fixed by capability; writable and set to one when both supported.
// - Parity response set: detected parity errors drive the error pin.
// - Parity response clear: still flag detected error, never drive error pin.
// - Parity response bit resets to zero.
// - Parity always generated on driven cycles, checking enabled or not.
// - Snoop bit not writable, stays zero: palette writes are claimed as memory writes, never captured.
// - Write-invalidate only while its enable is one; else plain memory write.
// - Special cycles ignored while monitor bit zero, its reset value.
// - No initiator transactions while bus master enable is zero.
// - Memory transactions claimed only while memory space enable is one.
// - I/O transactions claimed only while I/O space enable is one.
// - All-zero command disconnects the device except configuration accesses.
module cmd_ctrl
  import cmd_ctrl_pkg::*;
#(
  parameter logic [1:0] step_capability = step_never
)(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Configuration access
  input wire cfg_req_t cfg_req,
  output var logic [31:0] cfg_rdata,
  // Target decode requests
  input wire logic mem_hit,
  input wire logic io_hit,
  input wire logic palette_write,
  input wire logic special_cycle,
  // Master requests
  input wire logic master_req,
  input wire logic master_wants_mwi,
  // Parity check and generation
  input wire logic parity_error,
  input wire logic [31:0] drive_ad,
  input wire logic [3:0] drive_cbe,
  input wire logic drive_en,
  output var logic par,
  output var logic par_oe,
  output var logic perr_n,
  output var logic perr_oe,
  // Decisions toward the bus logic
  output var logic claim,
  output var logic snoop_capture,
  output var logic special_seen,
  output var logic master_grant,
  output var logic use_mwi,
  output var enables_t enables
);

  cmd_state_t state_reg, state_next;
  logic [31:0] rdata_reg, rdata_next;
  logic claim_reg, claim_next;
  logic snoop_reg, snoop_next;
  logic special_reg, special_next;
  logic grant_reg, grant_next;
  logic mwi_reg, mwi_next;
  enables_t en_reg, en_next;
  logic [15:0] wmask, wdata16, step_rd;
  logic cmd_hit, stat_hit;
  // Stepping bit comes out of reset at one only when software may change it
  localparam logic [15:0] step_init = (step_capability == step_either) ? (16'h0001 << cmd_step_bit) : cmd_reset_value;

  // Stepping bit is writable only when both modes are possible
  always_comb begin
    wmask = cmd_write_mask;
    step_rd = cmd_reset_value;
    if (step_capability == step_either) begin
      wmask[cmd_step_bit] = 1'b1;
    end
    if (step_capability == step_always) begin
      step_rd[cmd_step_bit] = 1'b1;
    end
  end

  // Byte enables are active low; both bytes of the word at offset 4
  always_comb begin
    cmd_hit = cfg_req.addr[7:2] == cmd_reg_offset[7:2];
    stat_hit = cfg_req.addr[7:2] == stat_reg_offset[7:2];
    wdata16 = state_reg.cmd;
    if (!cfg_req.be[0]) begin
      wdata16[7:0] = cfg_req.wdata[7:0];
    end
    if (!cfg_req.be[1]) begin
      wdata16[15:8] = cfg_req.wdata[15:8];
    end
  end

  // Next state of registers and decisions
  always_comb begin
    state_next = state_reg;
    rdata_next = rdata_reg;
    // Configuration write, masked to writable bits
    if (cfg_req.wr && cmd_hit) begin
      state_next.cmd = (wdata16 & wmask) | (state_reg.cmd & ~wmask) | step_rd;
    end
    // Status flag: writing one to bit 31 clears it, a new error wins
    if (cfg_req.wr && cmd_hit && !cfg_req.be[3] && cfg_req.wdata[16 + stat_dpe_bit]) begin
      state_next.detected_parity_error_flag = 1'b0;
    end
    if (parity_error) begin
      state_next.detected_parity_error_flag = 1'b1;
    end
    // Error pin only when parity response is on
    state_next.perr_n = !(parity_error && state_reg.cmd[cmd_parity_bit]);
    state_next.perr_oe = parity_error && state_reg.cmd[cmd_parity_bit];
    // Read data: command in low half, status in high half
    if (cfg_req.rd && (cmd_hit || stat_hit)) begin
      rdata_next = {stat_fixed_value | ({15'h0000, state_reg.detected_parity_error_flag} << stat_dpe_bit), state_reg.cmd | step_rd};
    end else if (cfg_req.rd) begin
      rdata_next = 32'h0000_0000;
    end
    // Target claim gated by the space enables; zero command disconnects all
    en_next.mem_claim = state_reg.cmd[cmd_mem_bit];
    en_next.io_claim = state_reg.cmd[cmd_io_bit];
    en_next.snoop_palette = state_reg.cmd[cmd_snoop_bit];
    en_next.special_monitor = state_reg.cmd[cmd_special_bit];
    en_next.master_ok = state_reg.cmd[cmd_bm_bit];
    en_next.mwi_ok = state_reg.cmd[cmd_mwi_bit];
    claim_next = ((mem_hit && state_reg.cmd[cmd_mem_bit]) || (io_hit && state_reg.cmd[cmd_io_bit]))
      && !(palette_write && state_reg.cmd[cmd_snoop_bit]);
    snoop_next = palette_write && state_reg.cmd[cmd_snoop_bit];
    special_next = special_cycle && state_reg.cmd[cmd_special_bit];
    grant_next = master_req && state_reg.cmd[cmd_bm_bit];
    mwi_next = master_req && master_wants_mwi && state_reg.cmd[cmd_bm_bit]
      && state_reg.cmd[cmd_mwi_bit];
  end

  // Single register stage; reset leaves every enable off
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg <= '{cmd: cmd_reset_value | step_init, detected_parity_error_flag: 1'b0, perr_n: 1'b1, perr_oe: 1'b0};
      rdata_reg <= 32'h0000_0000;
      claim_reg <= 1'b0;
      snoop_reg <= 1'b0;
      special_reg <= 1'b0;
      grant_reg <= 1'b0;
      mwi_reg <= 1'b0;
      en_reg <= '0;
    end else begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
      claim_reg <= claim_next;
      snoop_reg <= snoop_next;
      special_reg <= special_next;
      grant_reg <= grant_next;
      mwi_reg <= mwi_next;
      en_reg <= en_next;
    end
  end

  // Parity generation stays on regardless of checking
  parity_gen u_parity (
    .clock(clock),
    .resetn(resetn),
    .ad(drive_ad),
    .cbe(drive_cbe),
    .drive(drive_en),
    .par(par),
    .par_oe(par_oe)
  );

  // Outputs straight from flops
  assign cfg_rdata = rdata_reg;
  assign perr_n = state_reg.perr_n;
  assign perr_oe = state_reg.perr_oe;
  assign claim = claim_reg;
  assign snoop_capture = snoop_reg;
  assign special_seen = special_reg;
  assign master_grant = grant_reg;
  assign use_mwi = mwi_reg;
  assign enables = en_reg;

  // Checks
  chk_mem_gate: assert property (@(posedge clock) disable iff (!resetn)
    (mem_hit && !io_hit && !state_reg.cmd[cmd_mem_bit]) |=> !claim) else $error("memory claim while disabled");
  chk_io_gate: assert property (@(posedge clock) disable iff (!resetn)
    (io_hit && !mem_hit && !state_reg.cmd[cmd_io_bit]) |=> !claim) else $error("io claim while disabled");
  chk_master_gate: assert property (@(posedge clock) disable iff (!resetn)
    master_grant |-> $past(state_reg.cmd[cmd_bm_bit]) && $past(master_req)) else $error("master without enable");
  chk_mwi_gate: assert property (@(posedge clock) disable iff (!resetn)
    use_mwi |-> $past(state_reg.cmd[cmd_mwi_bit])) else $error("mwi without enable");
  chk_perr_gate: assert property (@(posedge clock) disable iff (!resetn)
    (parity_error && !state_reg.cmd[cmd_parity_bit]) |=> perr_n && !perr_oe) else $error("perr while off");
  chk_perr_drive: assert property (@(posedge clock) disable iff (!resetn)
    (parity_error && state_reg.cmd[cmd_parity_bit]) |=> !perr_n && perr_oe) else $error("perr not driven");
  chk_dpe_set: assert property (@(posedge clock) disable iff (!resetn)
    parity_error |=> state_reg.detected_parity_error_flag) else $error("parity flag lost");
  chk_reset_off: assert property (@(posedge clock)
    !resetn |=> state_reg.cmd[cmd_parity_bit] == 1'b0 && !state_reg.cmd[cmd_bm_bit]) else $error("reset value wrong");
  chk_special_gate: assert property (@(posedge clock) disable iff (!resetn)
    special_seen |-> $past(state_reg.cmd[cmd_special_bit])) else $error("special seen while off");
  chk_parity_out: assert property (@(posedge clock) disable iff (!resetn)
    drive_en |=> par == $past(^{drive_ad, drive_cbe}) && par_oe) else $error("bad parity");
  cov_claim: cover property (@(posedge clock) disable iff (!resetn) claim);
  cov_snoop: cover property (@(posedge clock) disable iff (!resetn) snoop_capture);
  cov_mwi: cover property (@(posedge clock) disable iff (!resetn) use_mwi);
  cov_perr: cover property (@(posedge clock) disable iff (!resetn) perr_oe);

endmodule : cmd_ctrl
`default_nettype wire

// [bus_agent.sv]
// Bus agent model raising target, master and parity events toward the block
`timescale 1ns/1ps
`default_nettype none
module bus_agent (
  // Reset
  input wire logic resetn,
  // Event selector from the bench
  input wire logic [2:0] op,
  // Decoded bus events
  output var logic mem_hit,
  output var logic io_hit,
  output var logic palette_write,
  output var logic special_cycle,
  output var logic master_req,
  output var logic master_wants_mwi,
  output var logic parity_error
);
  // One level per event; a palette write is also a memory write, so it hits too
  always_comb begin
    mem_hit = resetn && (op == 3'h1 || op == 3'h3);
    io_hit = resetn && op == 3'h2;
    palette_write = resetn && op == 3'h3;
    special_cycle = resetn && op == 3'h4;
    master_req = resetn && (op == 3'h5 || op == 3'h6);
    master_wants_mwi = resetn && op == 3'h6;
    parity_error = resetn && op == 3'h7; // Held one cycle, so a pulse
  end
endmodule : bus_agent
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the command register low byte block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cmd_ctrl_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  cfg_req_t req = '0;
  logic [2:0] op = 3'h0;
  logic [31:0] drive_ad = 32'h0;
  logic [3:0] drive_cbe = 4'h0;
  logic drive_en = 1'b0;
  logic [31:0] cfg_rdata, rd_val;
  logic mem_hit, io_hit, palette_write, special_cycle, master_req, master_wants_mwi, parity_error;
  logic par, par_oe, perr_n, perr_oe, claim, snoop_capture, special_seen, master_grant, use_mwi;
  enables_t enables;
  logic [31:0] step_rdata;
  int fails = 0;
  int num_checks = 0;
  // 100 ns period
  always #50 clock = ~clock;
  bus_agent u_agent (.resetn(resetn), .op(op), .mem_hit(mem_hit), .io_hit(io_hit),
    .palette_write(palette_write), .special_cycle(special_cycle), .master_req(master_req),
    .master_wants_mwi(master_wants_mwi), .parity_error(parity_error));
  cmd_ctrl u_dut (.clock(clock), .resetn(resetn), .cfg_req(req), .cfg_rdata(cfg_rdata),
    .mem_hit(mem_hit), .io_hit(io_hit), .palette_write(palette_write), .special_cycle(special_cycle),
    .master_req(master_req), .master_wants_mwi(master_wants_mwi), .parity_error(parity_error),
    .drive_ad(drive_ad), .drive_cbe(drive_cbe), .drive_en(drive_en), .par(par), .par_oe(par_oe),
    .perr_n(perr_n), .perr_oe(perr_oe), .claim(claim), .snoop_capture(snoop_capture),
    .special_seen(special_seen), .master_grant(master_grant), .use_mwi(use_mwi), .enables(enables));
  // Second copy whose stepping bit is writable, sharing the configuration bus
  cmd_ctrl #(.step_capability(step_either)) u_step (.clock(clock), .resetn(resetn), .cfg_req(req),
    .cfg_rdata(step_rdata), .mem_hit(mem_hit), .io_hit(io_hit), .palette_write(palette_write),
    .special_cycle(special_cycle), .master_req(master_req), .master_wants_mwi(master_wants_mwi),
    .parity_error(parity_error), .drive_ad(drive_ad), .drive_cbe(drive_cbe), .drive_en(drive_en),
    .par(), .par_oe(), .perr_n(), .perr_oe(), .claim(), .snoop_capture(), .special_seen(),
    .master_grant(), .use_mwi(), .enables());
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One configuration cycle; read data is taken once it has landed
  task automatic cfg(input logic r, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clock);
    req <= '{rd: r, wr: ~r, addr: a, be: b, wdata: d};
    @(posedge clock);
    req <= '0;
    @(posedge clock);
    #1 rd_val = cfg_rdata;
  endtask : cfg
  // One bus event, decisions looked at in the cycle they stand
  task automatic ev(input logic [2:0] o, input logic [4:0] e);
    @(posedge clock);
    op <= o;
    @(posedge clock);
    op <= 3'h0;
    #1 check({27'h0, claim, snoop_capture, special_seen, master_grant, use_mwi}, {27'h0, e});
  endtask : ev
  task automatic complete_run;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // Whole sequence needs about eighty cycles; allow a thousand
  initial begin
    #100us;
    fails++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    cfg(1'b1, 8'h04, 4'h0, 32'h0);
    check(rd_val, {stat_fixed_value, cmd_reset_value});
    check(step_rdata, {stat_fixed_value, 16'h0080});
    ev(3'h1, 5'h00);
    ev(3'h2, 5'h00);
    ev(3'h6, 5'h00);
    ev(3'h4, 5'h00);
    // Set every bit; only the writable ones stick
    cfg(1'b0, 8'h04, 4'h0, 32'h0000ffff);
    cfg(1'b1, 8'h04, 4'h0, 32'h0);
    check(rd_val, {stat_fixed_value, cmd_write_mask});
    check(step_rdata, {stat_fixed_value, cmd_write_mask | 16'h0080});
    check({26'h0, enables}, {26'h0, 6'b110011});
    ev(3'h1, 5'h10);
    ev(3'h2, 5'h10);
    ev(3'h3, 5'h10);
    ev(3'h4, 5'h00);
    ev(3'h5, 5'h02);
    ev(3'h6, 5'h03);
    // Parity error with response on, then clear the flag
    ev(3'h7, 5'h00);
    check({30'h0, perr_n, perr_oe}, 32'h1);
    cfg(1'b1, 8'h04, 4'h0, 32'h0);
    check(rd_val, {stat_fixed_value | 16'h8000, cmd_write_mask});
    cfg(1'b0, 8'h04, 4'h7, 32'h80000000);
    cfg(1'b1, 8'h04, 4'h0, 32'h0);
    check(rd_val, {stat_fixed_value, cmd_write_mask});
    // Response off: flag only, pin left alone, traffic goes on
    cfg(1'b0, 8'h04, 4'hc, 32'h00000017);
    ev(3'h7, 5'h00);
    check({30'h0, perr_n, perr_oe}, 32'h2);
    cfg(1'b1, 8'h04, 4'h0, 32'h0);
    check(rd_val, {stat_fixed_value | 16'h8000, 16'h0017});
    ev(3'h1, 5'h10);
    // Parity still made with checking off
    @(posedge clock);
    drive_ad <= 32'h80000001;
    drive_cbe <= 4'h7;
    drive_en <= 1'b1;
    @(posedge clock);
    drive_en <= 1'b0;
    #1 check({30'h0, par_oe, par}, {30'h0, 1'b1, 1'b1});
    // No byte enables and a foreign address change nothing
    cfg(1'b0, 8'h04, 4'hf, 32'h0);
    cfg(1'b1, 8'h04, 4'h0, 32'h0);
    check(rd_val, {stat_fixed_value | 16'h8000, 16'h0017});
    cfg(1'b0, 8'h08, 4'h0, 32'hffffffff);
    cfg(1'b1, 8'h08, 4'h0, 32'h0);
    check(rd_val, 32'h0);
    // All-zero command: off the bus, configuration still answers
    cfg(1'b0, 8'h04, 4'h0, 32'h0);
    ev(3'h1, 5'h00);
    ev(3'h2, 5'h00);
    ev(3'h6, 5'h00);
    cfg(1'b1, 8'h04, 4'h0, 32'h0);
    check(rd_val, {stat_fixed_value | 16'h8000, 16'h0000});
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
